// ===== pkg/spc_regs.svh
// Contract
// - four free-running 16-bit edge counters
// - each scan reports difference, stores new value
// - difference taken modulo counter width
// - several wraps within one scan go undetected
// - first accumulate only arms the channel
// - format select: zero count, one frequency
// - count resolution one, frequency count over interval
// - type, enable and format set per channel
// - pulse mode on switch channel enables pull-up
// - switch channel counts pulses to 1 kHz
// - switch channel pulse/closure, second channel AC
// - digital channels refuse the AC input type
// - period timer counts 70 ns ticks (the code counts 17-clock ticks, 68 ns at 250 MHz)
// - cycle counted on low-to-high threshold crossing
// - period input picks one of five channels
// - period timer detects cycles to 150 kHz
// - scan timebase within 3 ppm plus 10 us
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SPC_CTRL 8'h00
`define SPC_CHCFG 8'h04
`define SPC_SCAN_MS 8'h08
`define SPC_STATUS 8'h0c
`define SPC_PER_CTRL 8'h10
`define SPC_PER_RES 8'h14
`define SPC_RES_BASE 8'h20

// ****************************************
// fields and reset values
// ****************************************
`define SPC_CFG_EN 0
`define SPC_CFG_FMT 1
`define SPC_CFG_TYPE 2
`define SPC_CFG_W 3
`define SPC_CFG_WMASK 12'h6ff
`define SPC_PER_START 3
`define SPC_PER_N_LSB 16
`define SPC_SE_NUM 3'h5
`define SPC_SCAN_MS_RST 16'h03e8
`define SPC_CNT_W 16
`define SPC_FREQ_SCALE 32'h000003e8
`define SPC_DIV_STEPS 5'h1f

// ****************************************
// timing
// ****************************************
`define SPC_CLK_MHZ 250
`define SPC_TICK_NS 70
`define SPC_TICK_CYC ((`SPC_TICK_NS * `SPC_CLK_MHZ) / 1000)
`define SPC_MS_NS 1000000
`define SPC_MS_CYC ((`SPC_MS_NS / 1000) * `SPC_CLK_MHZ)

`endif

// ===== pkg/spc_pkg.sv
package spc_pkg;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_DIV,
        ACC_WR
    } spc_acc_t;
endpackage

// ===== src/spc_res_mem.sv
`timescale 1ns/1ps
`default_nettype none
module spc_res_mem #(
    parameter int W = 32,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [$clog2(D)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(D)-1:0] raddr,
    output logic [W-1:0] rdata
);
    if (D < 2 || W < 1) begin : g_chk
        $error("spc_res_mem: unsupported size");
    end

    logic [W-1:0] mem [D];

    // write-before-read is not offered: a same-address read returns the old word
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== src/spc_top.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.svh"
module spc_top #(
    parameter int MS_CYCLES = `SPC_MS_CYC,
    parameter int CNT_W = `SPC_CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic switch_pulse_input,
    input wire logic low_level_ac_input,
    input wire logic digital_io_one,
    input wire logic digital_io_two,
    input wire logic [4:0] se_below_low,
    input wire logic [4:0] se_above_high,
    output logic pull_up_enable,
    output logic low_level_ac_enable
);
    // ****************************************
    // parameters and state
    // ****************************************
    if (MS_CYCLES < 2 || CNT_W < 2 || CNT_W > 16) begin : g_chk
        $error("spc_top: unsupported parameter value");
    end

    localparam int MSW = $clog2(MS_CYCLES);
    localparam int NA = 14;
    localparam logic [4:0] TICK_LAST = 5'(`SPC_TICK_CYC - 1);

    typedef struct packed {
        logic [NA-1:0] s1;
        logic [NA-1:0] s2;
        logic [NA-1:0] s3;
        logic [3:0][CNT_W-1:0] cnt;
        logic [3:0][CNT_W-1:0] prev;
        logic [3:0][CNT_W-1:0] diff;
        logic [3:0] armed;
        logic [3:0] pend;
        logic [3:0] valid;
        logic [11:0] cfg;
        logic run;
        logic [15:0] scan_ms;
        logic [MSW-1:0] ms_cnt;
        logic [15:0] scan_cnt;
        spc_pkg::spc_acc_t st;
        logic [1:0] ch;
        logic [31:0] quot;
        logic [15:0] rem;
        logic [4:0] bitc;
        logic mem_we;
        logic [1:0] mem_waddr;
        logic [31:0] mem_wdata;
        logic per_busy;
        logic per_done;
        logic per_started;
        logic per_arm;
        logic [2:0] per_sel;
        logic [15:0] per_n;
        logic [15:0] per_edges;
        logic [4:0] per_pre;
        logic [31:0] per_ticks;
        logic [31:0] per_res;
        logic a_write;
        logic a_mem;
        logic [7:0] a_addr;
        logic [31:0] rdata;
    } spc_state_t;

    spc_state_t r;
    spc_state_t n;
    logic [NA-1:0] async_in;
    logic [NA-1:0] rise;
    logic [NA-1:0] fall;
    logic scan_tick;
    logic per_lo;
    logic per_hi;
    logic per_cyc;
    logic [1:0] sel_ch;
    logic [16:0] rsh;
    logic [31:0] mem_rdata;

    function automatic logic cfg_bit(input logic [11:0] cfg, input int ch, input int pos);
        return cfg[ch * `SPC_CFG_W + pos];
    endfunction

    // pins: [3:0] pulse channels, [8:4] below-low, [13:9] above-high
    assign async_in = {se_above_high, se_below_low, digital_io_two, digital_io_one,
                       low_level_ac_input, switch_pulse_input};

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        n = r;
        n.mem_we = 1'b0;
        n.a_write = 1'b0;
        scan_tick = 1'b0;
        sel_ch = 2'h0;
        rsh = '0;
        // stage one feeds stage two only
        n.s1 = async_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        rise = r.s2 & ~r.s3;
        fall = ~r.s2 & r.s3;

        // counters run whether or not the channel is enabled; no rate limit beyond clk/2
        for (int i = 0; i < 4; i++) begin
            if ((i == 0 && cfg_bit(r.cfg, 0, `SPC_CFG_TYPE)) ? fall[0] : rise[i]) begin
                n.cnt[i] = r.cnt[i] + CNT_W'(1);
            end
        end

        // scan timebase is an exact cycle count, so its error is the clock's own
        if (r.run) begin
            if (r.ms_cnt == MSW'(MS_CYCLES - 1)) begin
                n.ms_cnt = '0;
                if (r.scan_cnt == r.scan_ms - 16'h1) begin
                    n.scan_cnt = '0;
                    scan_tick = 1'b1;
                end else begin
                    n.scan_cnt = r.scan_cnt + 16'h1;
                end
            end else begin
                n.ms_cnt = r.ms_cnt + MSW'(1);
            end
        end else begin
            n.ms_cnt = '0;
            n.scan_cnt = '0;
        end

        // result engine; clears pend before the scan below may set it again
        case (r.st)
            spc_pkg::ACC_IDLE: begin
                for (int i = 3; i >= 0; i--) begin
                    if (r.pend[i]) begin
                        sel_ch = 2'(i);
                    end
                end
                if (r.pend != 4'h0) begin
                    n.ch = sel_ch;
                    n.pend[sel_ch] = 1'b0;
                    n.rem = '0;
                    n.bitc = `SPC_DIV_STEPS;
                    if (cfg_bit(r.cfg, 32'(sel_ch), `SPC_CFG_FMT)) begin
                        n.quot = 32'(r.diff[sel_ch]) * `SPC_FREQ_SCALE;
                        n.st = spc_pkg::ACC_DIV;
                    end else begin
                        n.quot = 32'(r.diff[sel_ch]);
                        n.st = spc_pkg::ACC_WR;
                    end
                end
            end
            spc_pkg::ACC_DIV: begin
                // restoring division by the interval in ms; hertz, truncated
                rsh = {r.rem, r.quot[31]};
                if (rsh >= {1'b0, r.scan_ms}) begin
                    n.rem = 16'(rsh - {1'b0, r.scan_ms});
                    n.quot = {r.quot[30:0], 1'b1};
                end else begin
                    n.rem = rsh[15:0];
                    n.quot = {r.quot[30:0], 1'b0};
                end
                if (r.bitc == 5'h00) begin
                    n.st = spc_pkg::ACC_WR;
                end else begin
                    n.bitc = r.bitc - 5'h01;
                end
            end
            spc_pkg::ACC_WR: begin
                n.mem_we = 1'b1;
                n.mem_waddr = r.ch;
                n.mem_wdata = r.quot;
                n.valid[r.ch] = 1'b1;
                n.st = spc_pkg::ACC_IDLE;
            end
            default: n.st = spc_pkg::ACC_IDLE;
        endcase

        // accumulate runs by itself every scan, so no scan is ever skipped
        if (scan_tick) begin
            for (int i = 0; i < 4; i++) begin
                if (cfg_bit(r.cfg, i, `SPC_CFG_EN)) begin
                    if (r.armed[i]) begin
                        // modulo subtraction hides one wrap but not two
                        n.diff[i] = r.cnt[i] - r.prev[i];
                        n.pend[i] = 1'b1;
                    end
                    // an edge in this cycle lands in n.cnt and is kept for next scan
                    n.prev[i] = r.cnt[i];
                    n.armed[i] = 1'b1;
                end
            end
        end

        // period timer
        per_lo = r.s2[4 + 32'(r.per_sel)];
        per_hi = r.s2[9 + 32'(r.per_sel)];
        per_cyc = r.per_busy && r.per_arm && per_hi;
        if (r.per_busy) begin
            if (per_lo) begin
                n.per_arm = 1'b1;
            end else if (per_cyc) begin
                n.per_arm = 1'b0;
            end
            if (r.per_started) begin
                // one tick per 17 clocks, the nearest whole cycle count below 70 ns
                if (r.per_pre == TICK_LAST) begin
                    n.per_pre = 5'h00;
                    n.per_ticks = r.per_ticks + 32'h1;
                end else begin
                    n.per_pre = r.per_pre + 5'h01;
                end
                if (per_cyc) begin
                    n.per_edges = r.per_edges + 16'h1;
                    if (r.per_edges + 16'h1 == r.per_n) begin
                        n.per_res = n.per_ticks; // a tick ending on this edge counts too
                        n.per_busy = 1'b0;
                        n.per_done = 1'b1;
                    end
                end
            end else if (per_cyc) begin
                n.per_started = 1'b1;
            end
        end

        // bus data phase: writes
        if (r.a_write) begin
            case (r.a_addr)
                `SPC_CTRL: n.run = hwdata[0];
                `SPC_CHCFG: n.cfg = hwdata[11:0] & `SPC_CFG_WMASK;
                `SPC_SCAN_MS: begin
                    if (hwdata[15:0] != 16'h0) begin
                        n.scan_ms = hwdata[15:0];
                    end
                end
                `SPC_PER_CTRL: begin
                    n.per_sel = hwdata[2:0];
                    n.per_n = hwdata[31:`SPC_PER_N_LSB];
                    if (hwdata[`SPC_PER_START] && hwdata[2:0] < `SPC_SE_NUM
                        && hwdata[31:`SPC_PER_N_LSB] != 16'h0) begin
                        n.per_busy = 1'b1;
                        n.per_done = n.per_done && r.per_busy;
                        n.per_started = 1'b0;
                        n.per_arm = 1'b0;
                        n.per_edges = '0;
                        n.per_pre = '0;
                        n.per_ticks = '0;
                    end
                end
                default: begin
                end
            endcase
        end

        // bus address phase: reads see the write that is finishing now
        if (hsel && htrans[1] && hready) begin
            n.a_write = hwrite;
            n.a_addr = haddr[7:0];
            n.a_mem = haddr[7:4] == 4'(`SPC_RES_BASE >> 4) && n.valid[haddr[3:2]];
            n.rdata = '0;
            case (haddr[7:0])
                `SPC_CTRL: n.rdata = {31'h0, n.run};
                `SPC_CHCFG: n.rdata = {20'h0, n.cfg};
                `SPC_SCAN_MS: n.rdata = {16'h0, n.scan_ms};
                `SPC_STATUS: n.rdata = {22'h0, n.per_done, n.per_busy, n.armed, n.valid};
                `SPC_PER_CTRL: n.rdata = {n.per_n, 13'h0, n.per_sel};
                `SPC_PER_RES: n.rdata = n.per_res;
                default: n.rdata = '0;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r <= '0;
            r.scan_ms <= `SPC_SCAN_MS_RST;
            r.s1 <= '1; // idle pin level, so release makes no false edge
            r.s2 <= '1;
            r.s3 <= '1;
        end else if (ce) begin
            r <= n;
        end
    end

    spc_res_mem #(
        .W(32),
        .D(4)
    ) u_mem (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .we(r.mem_we),
        .waddr(r.mem_waddr),
        .wdata(r.mem_wdata),
        .raddr(haddr[3:2]),
        .rdata(mem_rdata)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.a_mem ? mem_rdata : r.rdata;
    assign pull_up_enable = r.cfg[`SPC_CFG_EN] & ~r.cfg[`SPC_CFG_TYPE];
    assign low_level_ac_enable = cfg_bit(r.cfg, 1, `SPC_CFG_EN) & cfg_bit(r.cfg, 1, `SPC_CFG_TYPE);

    // ****************************************
    // checks
    // ****************************************
    a_cnt_step: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (r.cnt[1] == $past(r.cnt[1]) || r.cnt[1] == $past(r.cnt[1]) + CNT_W'(1)))
        else $error("counter moved by more than one");
    a_snap_atomic: assert property (@(posedge clk) disable iff (!reset_n)
        ce && scan_tick && r.cfg[`SPC_CFG_EN] |=> r.prev[0] == $past(r.cnt[0]))
        else $error("snapshot not taken at scan");
    a_first_arms: assert property (@(posedge clk) disable iff (!reset_n)
        ce && scan_tick && r.cfg[`SPC_CFG_EN] && !r.armed[0] |=> r.armed[0] && !r.pend[0])
        else $error("first accumulate produced a result");
    a_mod_diff: assert property (@(posedge clk) disable iff (!reset_n)
        ce && scan_tick && r.cfg[`SPC_CFG_EN] && r.armed[0]
        |=> r.diff[0] == CNT_W'($past(r.cnt[0]) - $past(r.prev[0])))
        else $error("scan difference wrong");
    a_reset_clear: assert property (@(posedge clk)
        !reset_n |=> r.cnt == '0 && r.prev == '0 && r.armed == 4'h0)
        else $error("reset left state behind");
    a_pullup_mode: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(r.cfg[`SPC_CFG_EN]) && !r.cfg[`SPC_CFG_TYPE] |-> pull_up_enable)
        else $error("pull-up not enabled");
    a_ac_reject: assert property (@(posedge clk) disable iff (!reset_n)
        r.cfg[8] == 1'b0 && r.cfg[11] == 1'b0)
        else $error("AC type accepted on digital channel");
    a_fmt_count: assert property (@(posedge clk) disable iff (!reset_n)
        r.st == spc_pkg::ACC_WR && !cfg_bit(r.cfg, 32'(r.ch), `SPC_CFG_FMT)
        |-> r.quot == 32'(r.diff[r.ch]))
        else $error("count result differs from difference");
    a_freq_value: assert property (@(posedge clk) disable iff (!reset_n)
        r.st == spc_pkg::ACC_WR && cfg_bit(r.cfg, 32'(r.ch), `SPC_CFG_FMT)
        |-> r.quot == (32'(r.diff[r.ch]) * `SPC_FREQ_SCALE) / 32'(r.scan_ms))
        else $error("frequency result wrong");
    a_per_done: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(r.per_busy) && !$past(r.a_write)
        |-> r.per_done && r.per_res == $past(r.per_ticks) + 32'($past(r.per_pre) == TICK_LAST))
        else $error("period result not latched");
    a_scan_period: assert property (@(posedge clk) disable iff (!reset_n)
        scan_tick |-> r.run && r.scan_cnt == r.scan_ms - 16'h1)
        else $error("scan tick off schedule");
endmodule
`default_nettype wire

// ===== bench/spc_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pulse and level sensors on the far side
// ****************************************
module spc_sensor_model (
    input wire logic clk,
    output logic switch_pulse_input,
    output logic low_level_ac_input,
    output logic digital_io_one,
    output logic digital_io_two,
    output logic [4:0] se_below_low,
    output logic [4:0] se_above_high
);
    // pins have pull-ups, so idle is high; analog inputs rest at ground
    logic [3:0] pin = 4'hf;
    initial begin
        se_below_low = 5'h1f;
        se_above_high = 5'h00;
    end
    assign switch_pulse_input = pin[0];
    assign low_level_ac_input = pin[1];
    assign digital_io_one = pin[2];
    assign digital_io_two = pin[3];
    // two low and two high clocks per pulse; one low and one high clock is the narrowest the pins accept
    task automatic burst(input int ch, input int n);
        repeat (n) begin
            pin[ch] <= 1'b0;
            repeat (2) @(posedge clk);
            pin[ch] <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic lvl(input int s, input logic b, input logic a, input int len);
        se_below_low[s] <= b;
        se_above_high[s] <= a;
        repeat (len) @(posedge clk);
    endtask
    // 34-clock cycle; the second rise above the high level comes without
    // a dip below the low level, so it must not count as a cycle
    task automatic wave(input int s, input int n);
        repeat (n) begin
            lvl(s, 1'b1, 1'b0, 8);
            lvl(s, 1'b0, 1'b0, 3);
            lvl(s, 1'b0, 1'b1, 6);
            lvl(s, 1'b0, 1'b0, 3);
            lvl(s, 1'b0, 1'b1, 6);
            lvl(s, 1'b0, 1'b0, 8);
        end
        lvl(s, 1'b1, 1'b0, 1);
    endtask
endmodule
`default_nettype wire

// ===== bench/spc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_regs.svh"
module spc_top_bench;
    localparam int MS_CYC = 100;
    localparam int SCAN_MS = 3;
    localparam int SCAN = MS_CYC * SCAN_MS;
    localparam int CNT_W = 4;
    localparam int CNT_MOD = 1 << CNT_W;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, pull_up_enable, low_level_ac_enable;
    logic [31:0] hrdata;
    logic [31:0] v;
    logic sw_pin, ac_pin, io1_pin, io2_pin;
    logic [4:0] below, above;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    spc_top #(.MS_CYCLES(MS_CYC), .CNT_W(CNT_W)) u_spc_top (
        .clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .switch_pulse_input(sw_pin), .low_level_ac_input(ac_pin),
        .digital_io_one(io1_pin), .digital_io_two(io2_pin), .se_below_low(below),
        .se_above_high(above), .pull_up_enable(pull_up_enable),
        .low_level_ac_enable(low_level_ac_enable));
    spc_sensor_model u_spc_sensor_model (
        .clk(clk), .switch_pulse_input(sw_pin), .low_level_ac_input(ac_pin),
        .digital_io_one(io1_pin), .digital_io_two(io2_pin), .se_below_low(below),
        .se_above_high(above));

    // ****************************************
    // shared tasks
    // ****************************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            error_cnt = error_cnt + 1;
            $display("timeout at %0t", $time);
            close_out();
        end
    end
    task close_out();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; read data lands in v
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        v = hrdata;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(v, exp);
    endtask
    // pulses in one interval, then the results of the tick that closes it
    task t_scan(input int a, input int b, input int c, input int d, input logic hz);
        int n[4];
        int e;
        n = '{a, b, c, d};
        fork
            u_spc_sensor_model.burst(0, a);
            u_spc_sensor_model.burst(1, b);
            u_spc_sensor_model.burst(2, c);
            u_spc_sensor_model.burst(3, d);
            repeat (SCAN) @(posedge clk);
        join
        for (int k = 0; k < 4; k++) begin
            e = n[k] % CNT_MOD;
            if (hz) e = e * 1000 / SCAN_MS;
            rdchk(`SPC_RES_BASE + 8'(4 * k), 32'(e));
        end
        $display("scan test done");
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs();
        rdchk(`SPC_CTRL, 32'h0);
        rdchk(`SPC_SCAN_MS, 32'h3e8);
        rdchk(`SPC_STATUS, 32'h0);
        rdchk(8'h40, 32'h0);
        for (int k = 0; k < 4; k++) rdchk(`SPC_RES_BASE + 8'(4 * k), 32'h0);
        xfer(1'b1, `SPC_CHCFG, 32'hfff);
        rdchk(`SPC_CHCFG, 32'h6ff);
        chk({31'h0, pull_up_enable}, 32'h0);
        chk({31'h0, low_level_ac_enable}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        xfer(1'b1, `SPC_CHCFG, 32'h269);
        rdchk(`SPC_CHCFG, 32'h269);
        chk({31'h0, pull_up_enable}, 32'h1);
        $display("register test done");
    endtask
    task t_count();
        int k;
        xfer(1'b1, `SPC_SCAN_MS, 32'(SCAN_MS));
        // the timebase runs the accumulate on every tick
        xfer(1'b1, `SPC_CTRL, 32'h1);
        v = 32'h0;
        k = 0;
        while (v[7:4] !== 4'hf && k < 400) begin
            xfer(1'b0, `SPC_STATUS, 32'h0);
            k++;
        end
        chk(v, 32'hf0);
        repeat (150) @(posedge clk);
        t_scan(3, 5, 7, 9, 1'b0);
        rdchk(`SPC_STATUS, 32'hff);
        t_scan(9, 11, 13, 15, 1'b0);
        t_scan(2, 4, 6, 17, 1'b0);
        // switch closure on the first channel counts falling edges
        xfer(1'b1, `SPC_CHCFG, 32'h26d);
        t_scan(5, 1, 2, 3, 1'b0);
        chk({31'h0, pull_up_enable}, 32'h0);
        xfer(1'b1, `SPC_CHCFG, 32'h6fb);
        t_scan(2, 4, 6, 15, 1'b1);
        $display("count test done");
    endtask
    task t_period();
        for (int s = 0; s < 5; s++) begin
            xfer(1'b1, `SPC_PER_CTRL, {16'(s + 1), 12'h0, 1'b1, 3'(s)});
            xfer(1'b0, `SPC_STATUS, 32'h0);
            chk({31'h0, v[8]}, 32'h1);
            u_spc_sensor_model.wave(s, s + 3);
            xfer(1'b0, `SPC_STATUS, 32'h0);
            chk({30'h0, v[9:8]}, 32'h2);
            rdchk(`SPC_PER_RES, 32'(34 * (s + 1) / `SPC_TICK_CYC));
        end
        xfer(1'b1, `SPC_PER_CTRL, {16'h1, 12'h0, 1'b1, 3'h5});
        xfer(1'b0, `SPC_STATUS, 32'h0);
        chk({31'h0, v[8]}, 32'h0);
        xfer(1'b1, `SPC_PER_CTRL, {16'h0, 12'h0, 1'b1, 3'h1});
        xfer(1'b0, `SPC_STATUS, 32'h0);
        chk({31'h0, v[8]}, 32'h0);
        $display("period test done");
    endtask
    task t_reset();
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(`SPC_STATUS, 32'h0);
        rdchk(`SPC_CHCFG, 32'h0);
        rdchk(`SPC_SCAN_MS, 32'h3e8);
        for (int k = 0; k < 4; k++) rdchk(`SPC_RES_BASE + 8'(4 * k), 32'h0);
        chk({31'h0, pull_up_enable}, 32'h0);
        $display("reset test done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_count();
        t_period();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire
